// >>> core/lsr_sync.sv
`timescale 1ns/1ps
// Three-flop pin filter: the level moves only when stages two and three agree
module lsr_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic raw,
  output logic level
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  // Stage one feeds only stage two
  always_comb begin
    stage_next = {stage_reg[1:0], raw};
    level_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : level_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= {3{RESET_LEVEL}};
      level_reg <= RESET_LEVEL;
    end else if (ce) begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : lsr_sync

// >>> core/lsr_top.sv
`timescale 1ns/1ps
// Summary of operation
// - The identity register at offset Ah is read-only and always reads the same constant.
// - The identity register carries the part identifier in bits 7:4 and the revision in bits 3:0.
// - Each channel result is 16 bits over two bytes, channel 0 at Ch/Dh and channel 1 at Eh/Fh.
// - The four result registers are read-only and come out of reset as 00h.
// - Reading a channel's low byte copies its upper eight bits into a shadow that the high byte returns.
// - The shadow holds its value even when new conversions finish before the high byte is read.
// - A two-byte read starting at a low byte returns low then high in one transaction.
// - The first byte written after the address, if its top bit is set, is a command whose low nibble becomes the register pointer.
module lsr_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // Arbitrary value
  parameter logic [3:0] PART_ID = 4'h3, // Arbitrary value
  parameter logic [3:0] REV_ID = 4'h1 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic conv_done,
  input wire lsr_pkg::lsr_result_s conv_data,
  output logic [3:0] pointer
);
  localparam logic [7:0] ID_VALUE = {PART_ID, REV_ID};

  logic scl_s;
  logic sda_s;
  lsr_sync #(.RESET_LEVEL(1'b1)) u_sync_scl (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .raw(scl_in), .level(scl_s));
  lsr_sync #(.RESET_LEVEL(1'b1)) u_sync_sda (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .raw(sda_in), .level(sda_s));

  lsr_pkg::lsr_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic oe_reg, oe_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic first_reg, first_next;
  logic [3:0] ptr_reg, ptr_next;
  logic [3:0] idx_reg, idx_next;
  logic scl_prev_reg, sda_prev_reg;
  logic sda_low_reg;
  lsr_pkg::lsr_result_s res_reg, res_next;
  logic [7:0] shadow0_reg, shadow0_next;
  logic [7:0] shadow1_reg, shadow1_next;

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic load_now, cmd_now;
  logic [7:0] rd_byte;

  // Bus events seen on the filtered levels only
  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  assign start_ev = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_ev = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // Read data selection; unmapped offsets read zero
  always_comb begin
    case (idx_reg)
      lsr_pkg::OFF_IDENTITY: rd_byte = ID_VALUE;
      lsr_pkg::OFF_CH0_LOW: rd_byte = res_reg.ch0[7:0];
      lsr_pkg::OFF_CH0_HIGH: rd_byte = shadow0_reg;
      lsr_pkg::OFF_CH1_LOW: rd_byte = res_reg.ch1[7:0];
      lsr_pkg::OFF_CH1_HIGH: rd_byte = shadow1_reg;
      default: rd_byte = lsr_pkg::UNMAPPED_READ;
    endcase
  end

  // A byte is fetched after the address ack or after a host ack
  assign load_now = ce && scl_fall && !start_ev && !stop_ev &&
    ((state_reg == lsr_pkg::ST_AACK && rw_reg) || (state_reg == lsr_pkg::ST_MACK && !nack_reg));
  assign cmd_now = ce && scl_fall && !start_ev && !stop_ev && state_reg == lsr_pkg::ST_RX &&
    cnt_reg == lsr_pkg::BITS_PER_BYTE && first_reg && shift_reg[lsr_pkg::CMD_FLAG_BIT];

  // Serial link next state; start and stop win over everything
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    first_next = first_reg;
    ptr_next = ptr_reg;
    idx_next = idx_reg;
    if (start_ev) begin
      state_next = lsr_pkg::ST_ADDR;
      cnt_next = lsr_pkg::CNT_RESET;
      oe_next = 1'b0;
      idx_next = ptr_reg; // Each transaction starts at the stored pointer
    end else if (stop_ev) begin
      state_next = lsr_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        lsr_pkg::ST_ADDR, lsr_pkg::ST_RX: begin
          shift_next = {shift_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end
        lsr_pkg::ST_TX: cnt_next = cnt_reg + 4'h1;
        lsr_pkg::ST_MACK: nack_next = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        lsr_pkg::ST_ADDR: begin
          if (cnt_reg == lsr_pkg::BITS_PER_BYTE) begin
            if (shift_reg[7:1] == SLAVE_ADDR) begin
              rw_next = shift_reg[0];
              oe_next = 1'b1; // Acknowledge our address
              state_next = lsr_pkg::ST_AACK;
            end else begin
              state_next = lsr_pkg::ST_IDLE;
            end
          end
        end
        lsr_pkg::ST_AACK, lsr_pkg::ST_MACK: begin
          cnt_next = lsr_pkg::CNT_RESET;
          if (load_now) begin
            tx_next = rd_byte;
            oe_next = !rd_byte[7];
            idx_next = idx_reg + 4'h1; // Word reads walk to the high byte
            state_next = lsr_pkg::ST_TX;
          end else if (state_reg == lsr_pkg::ST_AACK) begin
            oe_next = 1'b0;
            first_next = 1'b1;
            state_next = lsr_pkg::ST_RX;
          end else begin
            oe_next = 1'b0;
            state_next = lsr_pkg::ST_IDLE;
          end
        end
        lsr_pkg::ST_RX: begin
          if (cnt_reg == lsr_pkg::BITS_PER_BYTE) begin
            if (cmd_now) begin
              ptr_next = shift_reg[lsr_pkg::CMD_ADDR_MSB:0];
              idx_next = shift_reg[lsr_pkg::CMD_ADDR_MSB:0];
            end
            first_next = 1'b0; // Data bytes never reach read-only registers
            oe_next = 1'b1;
            state_next = lsr_pkg::ST_WACK;
          end
        end
        lsr_pkg::ST_WACK: begin
          oe_next = 1'b0;
          cnt_next = lsr_pkg::CNT_RESET;
          state_next = lsr_pkg::ST_RX;
        end
        lsr_pkg::ST_TX: begin
          if (cnt_reg == lsr_pkg::BITS_PER_BYTE) begin
            oe_next = 1'b0; // Release for the host's ack
            state_next = lsr_pkg::ST_MACK;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = !tx_reg[6];
          end
        end
        default: state_next = lsr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lsr_pkg::ST_IDLE;
      cnt_reg <= lsr_pkg::CNT_RESET;
      shift_reg <= lsr_pkg::RESULT_RESET;
      tx_reg <= lsr_pkg::RESULT_RESET;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      first_reg <= 1'b0;
      ptr_reg <= lsr_pkg::PTR_RESET;
      idx_reg <= lsr_pkg::PTR_RESET;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      first_reg <= first_next;
      ptr_reg <= ptr_next;
      idx_reg <= idx_next;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      sda_low_reg <= 1'b0;
    end
  end

  // Results and shadows; a low-byte fetch freezes its high byte
  always_comb begin
    res_next = res_reg;
    shadow0_next = shadow0_reg;
    shadow1_next = shadow1_reg;
    if (conv_done) begin
      res_next = conv_data; // Both channels from one integration
    end
    if (load_now && idx_reg == lsr_pkg::OFF_CH0_LOW) begin
      shadow0_next = res_reg.ch0[15:8];
    end
    if (load_now && idx_reg == lsr_pkg::OFF_CH1_LOW) begin
      shadow1_next = res_reg.ch1[15:8];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= {lsr_pkg::WORD_RESET, lsr_pkg::WORD_RESET};
      shadow0_reg <= lsr_pkg::RESULT_RESET;
      shadow1_reg <= lsr_pkg::RESULT_RESET;
    end else if (ce) begin
      res_reg <= res_next;
      shadow0_reg <= shadow0_next;
      shadow1_reg <= shadow1_next;
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = sda_low_reg;
  assign sda_oe = oe_reg;
  assign pointer = ptr_reg;

  property p_id_const;
    @(posedge clk_sys) disable iff (!rst_n)
      load_now && idx_reg == lsr_pkg::OFF_IDENTITY |=> tx_reg == ID_VALUE;
  endproperty
  a_id_const: assert property (p_id_const) else $error("identity byte not constant");

  property p_id_fields;
    @(posedge clk_sys) disable iff (!rst_n)
      load_now && idx_reg == lsr_pkg::OFF_IDENTITY |=> tx_reg[7:4] == PART_ID && tx_reg[3:0] == REV_ID;
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("identity fields misplaced");

  property p_low_byte;
    @(posedge clk_sys) disable iff (!rst_n)
      load_now && idx_reg == lsr_pkg::OFF_CH1_LOW |=> tx_reg == $past(res_reg.ch1[7:0]) && oe_reg == !tx_reg[7];
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("channel low byte wrong");

  property p_reset_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      !$past(rst_n) |-> res_reg == {lsr_pkg::WORD_RESET, lsr_pkg::WORD_RESET} && shadow0_reg == lsr_pkg::RESULT_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("results not zero after reset");

  property p_shadow_capture;
    @(posedge clk_sys) disable iff (!rst_n)
      load_now && idx_reg == lsr_pkg::OFF_CH0_LOW |=> shadow0_reg == $past(res_reg.ch0[15:8]);
  endproperty
  a_shadow_capture: assert property (p_shadow_capture) else $error("shadow not captured");

  property p_shadow_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(load_now && idx_reg == lsr_pkg::OFF_CH0_LOW) |=> $stable(shadow0_reg);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed without low read");

  property p_word_high;
    @(posedge clk_sys) disable iff (!rst_n)
      load_now && idx_reg == lsr_pkg::OFF_CH0_HIGH |=> tx_reg == $past(shadow0_reg) ##0 idx_reg == lsr_pkg::OFF_CH1_LOW;
  endproperty
  a_word_high: assert property (p_word_high) else $error("high byte not from shadow");

  property p_command;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_now |=> ptr_reg == $past(shift_reg[lsr_pkg::CMD_ADDR_MSB:0]) ##1 ptr_reg == $past(ptr_reg);
  endproperty
  a_command: assert property (p_command) else $error("command pointer not stored");

  property p_update_together;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && conv_done |=> res_reg == $past(conv_data);
  endproperty
  a_update_together: assert property (p_update_together) else $error("channels not updated together");
endmodule : lsr_top

// >>> inc/lsr_pkg.sv
package lsr_pkg;
  // Register offsets
  localparam logic [3:0] OFF_IDENTITY = 4'ha;
  localparam logic [3:0] OFF_CH0_LOW = 4'hc;
  localparam logic [3:0] OFF_CH0_HIGH = 4'hd;
  localparam logic [3:0] OFF_CH1_LOW = 4'he;
  localparam logic [3:0] OFF_CH1_HIGH = 4'hf;
  // Identity field positions
  localparam int PART_MSB = 7;
  localparam int PART_LSB = 4;
  localparam int REV_MSB = 3;
  localparam int REV_LSB = 0;
  // Command byte layout
  localparam int CMD_FLAG_BIT = 7;
  localparam int CMD_ADDR_MSB = 3;
  // Reset values and the unmapped read value
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX = 3'b011,
    ST_WACK = 3'b100,
    ST_TX = 3'b101,
    ST_MACK = 3'b110
  } lsr_state_e;

  // Both channel results of one conversion travel together
  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } lsr_result_s;
endpackage : lsr_pkg

// >>> tb/lsr_host.sv
`timescale 1ns/1ps
// Bus host model: SCL push-pull, SDA open drain with pull-up
module lsr_host (
  input wire logic clk_sys,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda_wire,
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  logic host_low;
  // Released wire reads high through the pull-up, never the last value
  // The device's data value counts only while it drives; it must be low to ack
  assign sda_wire = ~host_low & (sda_oe ? sda_out : 1'b1);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // SDA moves two cycles into the low phase so it never races the SCL fall
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    host_low = ~b;
    tick(6);
    scl = 1'b1;
    tick(4);
    s = sda_wire;
    tick(4);
    scl = 1'b0;
  endtask : bit_io
  // Also serves as repeated start
  task automatic start();
    tick(2);
    host_low = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(8);
    host_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    host_low = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(8);
    host_low = 1'b0;
    tick(8);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  // Acks every byte but the last, so a word read continues to the high byte
  task automatic get_byte(input logic last);
    logic s;
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      v = {v[6:0], s};
    end
    bit_io(last, s);
    rx_byte = v;
    rx_stb = 1'b1;
    tick(1);
    rx_stb = 1'b0;
  endtask : get_byte
endmodule : lsr_host

// >>> tb/lsr_top_bench.sv
`timescale 1ns/1ps
module lsr_top_bench;
  localparam logic [6:0] ADDR = 7'h2a;
  localparam logic [7:0] IDENT = 8'h31;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic conv_done = 1'b0;
  lsr_pkg::lsr_result_s conv_data = '0;
  logic scl, sda_wire, sda_out, sda_oe, rx_stb;
  logic [7:0] rx_byte;
  logic [3:0] pointer;
  logic [31:0] seed = 32'h775a_47cf;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  lsr_top #(.SLAVE_ADDR(ADDR), .PART_ID(4'h3), .REV_ID(4'h1)) i_lsr_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .conv_data(conv_data), .pointer(pointer));
  lsr_host i_lsr_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda_wire(sda_wire),
    .rx_stb(rx_stb), .rx_byte(rx_byte));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Command byte sets the pointer; ack and stored pointer are checked
  task automatic set_ptr(input logic [3:0] p);
    logic a;
    i_lsr_host.start();
    i_lsr_host.wr_byte({ADDR, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    i_lsr_host.wr_byte({4'h8, p}, a);
    i_lsr_host.stop();
    chk({4'h0, pointer}, {4'h0, p});
  endtask : set_ptr
  // Reads n bytes from the pointer; expectations are queued beforehand
  task automatic rd(input int n);
    logic a;
    i_lsr_host.start();
    i_lsr_host.wr_byte({ADDR, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_lsr_host.get_byte(i == n - 1);
    end
    i_lsr_host.stop();
  endtask : rd
  // One conversion pulse carrying a random pair of results
  task automatic conv(output lsr_pkg::lsr_result_s r);
    seed = lfsr(seed);
    r = seed;
    @(negedge clk_sys);
    conv_done = 1'b1;
    conv_data = r;
    @(negedge clk_sys);
    conv_done = 1'b0;
  endtask : conv
  // Hang guard, far above the roughly 8.6k cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  // Every byte the host receives is matched with the oldest expectation
  always @(posedge clk_sys) begin
    if (rx_stb === 1'b1) begin
      chk(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : ~rx_byte);
    end
  end
  initial begin
    lsr_pkg::lsr_result_s r0;
    lsr_pkg::lsr_result_s r1;
    logic a;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    // Results before any conversion, all four bytes in one transaction
    set_ptr(4'hc);
    repeat (4) exp_q.push_back(8'h00);
    rd(4);
    // Identity, then a write attempt that must neither change it nor move the pointer
    set_ptr(4'ha);
    exp_q.push_back(IDENT);
    rd(1);
    i_lsr_host.start();
    i_lsr_host.wr_byte({ADDR, 1'b0}, a);
    i_lsr_host.wr_byte(8'h0c, a);
    i_lsr_host.wr_byte(8'hff, a);
    i_lsr_host.stop();
    chk({4'h0, pointer}, 8'h0a);
    exp_q.push_back(IDENT);
    rd(1);
    // Word reads of both channels after one conversion
    conv(r0);
    set_ptr(4'hc);
    exp_q.push_back(r0.ch0[7:0]);
    exp_q.push_back(r0.ch0[15:8]);
    exp_q.push_back(r0.ch1[7:0]);
    exp_q.push_back(r0.ch1[15:8]);
    rd(4);
    // Low byte, two newer conversions, then the high byte from the shadow
    conv(r0);
    set_ptr(4'he);
    exp_q.push_back(r0.ch1[7:0]);
    rd(1);
    conv(r1);
    conv(r1);
    set_ptr(4'hf);
    exp_q.push_back(r0.ch1[15:8]);
    rd(1);
    // A conversion pulse while the clock enable is low must not land
    @(negedge clk_sys);
    ce = 1'b0;
    conv(r0);
    @(negedge clk_sys);
    ce = 1'b1;
    repeat (2) @(negedge clk_sys);
    set_ptr(4'hc);
    exp_q.push_back(r1.ch0[7:0]);
    exp_q.push_back(r1.ch0[15:8]);
    rd(2);
    // Reset in mid-run clears results, shadows and pointer again
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({4'h0, pointer}, 8'h00);
    repeat (6) @(negedge clk_sys);
    set_ptr(4'hd);
    exp_q.push_back(8'h00);
    rd(1);
    set_ptr(4'hc);
    repeat (4) exp_q.push_back(8'h00);
    rd(4);
    // Unmapped offset, then a foreign address that must go unanswered
    set_ptr(4'h0);
    exp_q.push_back(8'h00);
    rd(1);
    i_lsr_host.start();
    i_lsr_host.wr_byte({ADDR ^ 7'h01, 1'b1}, a);
    i_lsr_host.stop();
    chk({7'h00, a}, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk(8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule : lsr_top_bench
